/* File: core/code_protect_pkg.sv */
// Shared constants for program memory code protection.
// Assumes a single 25 MHz clock domain.
package code_protect_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 24;
	// Word boundaries of segments (plain defaults)
	localparam logic [15:0] BOOT_END_SMALL  = 16'h0400;
	localparam logic [15:0] BOOT_END_MEDIUM = 16'h0800;
	localparam logic [15:0] BOOT_END_LARGE  = 16'h1000;
	localparam logic [15:0] MEM_TOP         = 16'h1600;
	// Debug reservation
	localparam logic [15:0] DBG_RAM_BYTES   = 16'h0050;
	localparam logic [1:0]  DBG_PIN_MASK    = 2'h3;
	// Register offsets of the plain register port
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_REFUSE = 4'h2;
	// Config field positions
	localparam int CFG_BOOT_SEL_LSB = 0;
	localparam int CFG_GEN_PROT     = 3;
	localparam int CFG_BOOT_WP      = 4;
	localparam int CFG_GEN_WP       = 5;
	localparam int CFG_DEBUG   = 6;
	localparam logic [7:0] CFG_RESET = 8'h3F;
	localparam int SERIAL_BITS = 8;
	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_ERASE = 2'h2,
		OP_FETCH = 2'h3
	} op_type;
	typedef enum logic [1:0] {
		SRC_CPU  = 2'h0,
		SRC_PROG = 2'h1
	} src_type;
endpackage

/* File: core/mem_req_if.sv */
// Carries one program memory request and its grant.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
interface mem_req_if;
	import code_protect_pkg::*;
	logic                  valid;
	code_protect_pkg::src_type src;
	code_protect_pkg::op_type  op;
	logic [ADDR_W-1:0]     addr;
	logic                  grant;
	logic                  refuse;
	modport requester (output valid, output src, output op, output addr, input grant, input refuse);
	modport checker_p (input valid, input src, input op, input addr, output grant, output refuse);
endinterface
`default_nettype wire

/* File: core/serial_prog_rx.sv */
// Shift receiver for programmer commands on clock and data pins.
// Assumes pins are already synchronised to clk.
`timescale 1ns/1ns
`default_nettype none
module serial_prog_rx
	import code_protect_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Synchronised pins
	input  wire logic pclk_s,
	input  wire logic pdat_s,
	// Assembled frame
	output logic [SERIAL_BITS-1:0] frame_q,
	output logic                   frame_done_q
);
	import code_protect_pkg::*;
	logic                 pclk_prev_q;
	logic [3:0]           count_q;
	logic [SERIAL_BITS-1:0] shift_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pclk_prev_q <= 1'b0;
			count_q <= 4'h0;
			shift_q <= '0;
			frame_q <= '0;
			frame_done_q <= 1'b0;
		end else begin
			pclk_prev_q <= pclk_s;
			frame_done_q <= 1'b0;
			// Data sampled on the rising programming clock
			if (pclk_s && !pclk_prev_q) begin
				shift_q <= {shift_q[SERIAL_BITS-2:0], pdat_s};
				if (count_q == 4'(SERIAL_BITS - 1)) begin
					count_q <= 4'h0;
					frame_q <= {shift_q[SERIAL_BITS-2:0], pdat_s};
					frame_done_q <= 1'b1;
				end else begin
					count_q <= count_q + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: core/protect_check.sv */
// Decides grant or refusal for one program memory request.
// Assumes configuration held stable after reset.
`timescale 1ns/1ns
`default_nettype none
module protect_check
	import code_protect_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Latched configuration
	input  wire logic [2:0] boot_segment_protect_sel,
	input  wire logic       general_segment_protect,
	input  wire logic       boot_write_protect_n,
	input  wire logic       general_write_protect_n,
	// Request
	mem_req_if.checker_p    req
);
	import code_protect_pkg::*;
	function automatic logic [15:0] boot_end(input logic [2:0] sel);
		case (sel)
			3'h7:    boot_end = 16'h0000;
			3'h6,
			3'h2:    boot_end = BOOT_END_SMALL;
			3'h5,
			3'h1:    boot_end = BOOT_END_MEDIUM;
			default: boot_end = BOOT_END_LARGE;
		endcase
	endfunction
	logic in_boot;
	logic boot_rd_prot;
	logic ext_block;
	logic self_block;
	always_comb begin
		in_boot = req.addr < boot_end(boot_segment_protect_sel);
		// Selections with msb low protect the boot segment
		boot_rd_prot = in_boot && !boot_segment_protect_sel[2];
		ext_block = (req.src == SRC_PROG) && req.op != OP_FETCH &&
			(boot_rd_prot || (!in_boot && !general_segment_protect));
		self_block = (req.src == SRC_CPU) &&
			(req.op == OP_WRITE || req.op == OP_ERASE) &&
			((in_boot && !boot_write_protect_n) ||
			(!in_boot && !general_write_protect_n));
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req.grant <= 1'b0;
			req.refuse <= 1'b0;
		end else begin
			// Checked on every request, fetches always pass
			req.grant <= req.valid && !ext_block && !self_block;
			req.refuse <= req.valid && (ext_block || self_block);
		end
	end
	fetch_free_a: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.src == SRC_CPU && req.op == OP_FETCH |=> req.grant)
		else $error("fetch refused");
	self_write_a: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.src == SRC_CPU && req.op == OP_ERASE && !in_boot
		&& !general_write_protect_n |=> req.refuse)
		else $error("erase not blocked");
	one_answer_a: assert property (@(posedge clk) disable iff (!nrst)
		!(req.grant && req.refuse))
		else $error("grant and refuse together");
	cover_refuse: cover property (@(posedge clk) disable iff (!nrst) req.refuse);
	cover_grant: cover property (@(posedge clk) disable iff (!nrst) req.grant);
endmodule
`default_nettype wire

/* File: core/code_protect_top.sv */
// Program memory code protection with serial programming port.
// Assumes pins asynchronous to clk; configuration bits stable at reset.
//
// Contract
// - The boot segment read/write protection comes from the three-bit boot select field.
// - The general segment read/write protection comes from the single general protect bit.
// - Active segment protection refuses programmer reads and writes but never normal fetches.
// - A write-protect bit at zero blocks internal write and erase to its segment.
// - Serial programming uses one clock line and one two-way data line from the programmer.
// - Debug control and data share the same clock and data pin pair; the code carries no debug traffic on the pins.
// - While debugging is on, the first 80 data RAM bytes and two pins are withheld.
`timescale 1ns/1ns
`default_nettype none
module code_protect_top
	import code_protect_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Configuration word bits
	input  wire logic [7:0] config_bits,
	// Programming pins
	input  wire logic prog_clock_pin,
	input  wire logic prog_data_pin_in,
	output logic      prog_data_pin_out,
	output logic      prog_data_pin_oe_n,
	// Internal memory request
	input  wire logic                        cpu_valid,
	input  wire code_protect_pkg::op_type    cpu_op,
	input  wire logic [code_protect_pkg::ADDR_W-1:0] cpu_addr,
	output logic                             mem_grant,
	output logic                             mem_refuse,
	// Data RAM and pin arbitration
	input  wire logic [15:0] ram_addr,
	output logic             ram_user_deny,
	output logic [1:0]       pins_reserved,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata
);
	import code_protect_pkg::*;
	logic [1:0] pclk_sync_q;
	logic [1:0] pdat_sync_q;
	logic [7:0] cfg_q;
	logic       cfg_loaded_q;
	logic [7:0] frame;
	logic       frame_done;
	logic [15:0] prog_addr_q;
	logic        prog_pending_q;
	code_protect_pkg::op_type prog_op_q;
	logic [7:0]  refuse_count_q;
	logic        debug_on;
	mem_req_if req ();

	// Pins pass two flops first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pclk_sync_q <= 2'h0;
			pdat_sync_q <= 2'h0;
		end else begin
			pclk_sync_q <= {pclk_sync_q[0], prog_clock_pin};
			pdat_sync_q <= {pdat_sync_q[0], prog_data_pin_in};
		end
	end

	// Captured after reset release, held until next reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= CFG_RESET;
			cfg_loaded_q <= 1'b0;
		end else if (!cfg_loaded_q) begin
			cfg_q <= config_bits;
			cfg_loaded_q <= 1'b1;
		end
	end
	assign debug_on = cfg_q[CFG_DEBUG];

	serial_prog_rx u_rx (
		.clk          (clk),
		.nrst         (nrst),
		.pclk_s       (pclk_sync_q[1]),
		.pdat_s       (pdat_sync_q[1]),
		.frame_q      (frame),
		.frame_done_q (frame_done)
	);

	// Frame: op[7:6], address shifts in six bits per frame from [5:0]; every frame except an op fetch frame issues a memory op, none carries debug
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prog_addr_q <= 16'h0000;
			prog_op_q <= OP_READ;
			prog_pending_q <= 1'b0;
		end else begin
			if (frame_done) begin
				prog_op_q <= op_type'(frame[7:6]);
				prog_addr_q <= {prog_addr_q[9:0], frame[5:0]};
				prog_pending_q <= frame[7:6] != OP_FETCH;
			end else if (prog_pending_q && !cpu_valid) begin
				// CPU has priority, programmer waits
				prog_pending_q <= 1'b0;
			end
		end
	end

	always_comb begin
		req.valid = cpu_valid || prog_pending_q;
		req.src = cpu_valid ? SRC_CPU : SRC_PROG;
		req.op = cpu_valid ? cpu_op : prog_op_q;
		req.addr = cpu_valid ? cpu_addr : prog_addr_q;
	end

	protect_check u_check (
		.clk                      (clk),
		.nrst                     (nrst),
		.boot_segment_protect_sel (cfg_q[CFG_BOOT_SEL_LSB +: 3]),
		.general_segment_protect  (cfg_q[CFG_GEN_PROT]),
		.boot_write_protect_n     (cfg_q[CFG_BOOT_WP]),
		.general_write_protect_n  (cfg_q[CFG_GEN_WP]),
		.req                      (req.checker_p)
	);

	logic src_prog_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem_grant <= 1'b0;
			mem_refuse <= 1'b0;
			src_prog_q <= 1'b0;
			refuse_count_q <= 8'h00;
		end else begin
			src_prog_q <= req.valid && req.src == SRC_PROG;
			mem_grant <= req.grant;
			mem_refuse <= req.refuse;
			// A refusal in the clearing cycle still counts
			if (reg_wr && reg_addr == REG_REFUSE)
				refuse_count_q <= req.refuse ? 8'h01 : 8'h00;
			else if (req.refuse && refuse_count_q != 8'hFF)
				refuse_count_q <= refuse_count_q + 8'h01;
		end
	end

	// Refusal answered on the data line: driven low acknowledge pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prog_data_pin_out <= 1'b0;
			prog_data_pin_oe_n <= 1'b1;
		end else begin
			prog_data_pin_out <= req.grant;
			prog_data_pin_oe_n <= !((req.grant || req.refuse) && src_prog_q);
		end
	end

	// Debug reservation of RAM and pins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ram_user_deny <= 1'b0;
			pins_reserved <= 2'h0;
		end else begin
			ram_user_deny <= debug_on && ram_addr < DBG_RAM_BYTES;
			pins_reserved <= debug_on ? DBG_PIN_MASK : 2'h0;
		end
	end

	// Register port, read data one cycle later
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CONFIG: reg_rdata <= cfg_q;
				REG_STATUS: reg_rdata <= {5'h00, debug_on, prog_pending_q, cfg_loaded_q};
				REG_REFUSE: reg_rdata <= refuse_count_q;
				default:    reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	cfg_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		cfg_loaded_q && $past(cfg_loaded_q) |-> $stable(cfg_q))
		else $error("configuration changed after capture");
	ram_resv_a: assert property (@(posedge clk) disable iff (!nrst)
		debug_on && ram_addr < DBG_RAM_BYTES |=> ram_user_deny)
		else $error("debug RAM not withheld");
	pin_resv_a: assert property (@(posedge clk) disable iff (!nrst)
		!debug_on |=> pins_reserved == 2'h0)
		else $error("pins withheld without debug");
	prog_block_a: assert property (@(posedge clk) disable iff (!nrst)
		req.valid && req.src == SRC_PROG && req.op == OP_READ &&
		!cfg_q[CFG_GEN_PROT] && req.addr >= BOOT_END_LARGE |=> ##1 mem_refuse)
		else $error("protected read granted");
	cover_debug: cover property (@(posedge clk) disable iff (!nrst) ram_user_deny);
	cover_frame: cover property (@(posedge clk) disable iff (!nrst) frame_done);
endmodule
`default_nettype wire

/* File: verification/prog_model.sv */
// Behavioural external programmer driving the clock and data pins.
// Assumes the bench resolves the shared data wire from the device output enable.
`timescale 1ns/1ns
`default_nettype none
module prog_model (
	// Pins towards the device
	output logic pclk,
	output logic pdat
);
	initial begin
		pclk = 1'b0;
		pdat = 1'b1;
	end
	// Clock stands still between frames; half sets prompt or slow pace
	task automatic send_frame(input logic [7:0] f, input int half);
		for (int i = 7; i >= 0; i--) begin
			pdat = f[i];
			#(half);
			pclk = 1'b1;
			#(half);
			pclk = 1'b0;
		end
		// Released line must not look like a held bit
		pdat = ~f[0];
	endtask
endmodule
`default_nettype wire

/* File: verification/program_memory_code_protection_tb.sv */
// Self-checking bench for the code protection block and its programming port.
// Assumes the programmer model in prog_model and the design package.
`timescale 1ns/1ns
`default_nettype none
module program_memory_code_protection_tb;
	import code_protect_pkg::*;
	typedef struct packed {
		logic [7:0]  cfg;
		op_type      op;
		logic [15:0] addr;
		logic        grant;
	} row_type;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  config_bits = 8'h3F;
	logic        cpu_valid = 1'b0;
	op_type      cpu_op = OP_READ;
	logic [15:0] cpu_addr = 16'h0000;
	logic [15:0] ram_addr = 16'h0000;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        pclk, mdat, dout, doe_n, grant, refuse, deny, pdat;
	logic [1:0]  pins;
	logic [7:0]  rdata;
	logic        ans_val = 1'b0;
	int          ans_cnt = 0;
	int          fail_count = 0;
	int          tests_run = 0;
	// Boundaries on both sides of each boot end
	row_type     rows [13] = '{
		'{8'h3F, OP_WRITE, 16'h0010, 1'b1}, '{8'h2B, OP_WRITE, 16'h0FFF, 1'b0},
		'{8'h2B, OP_WRITE, 16'h1000, 1'b1}, '{8'h2B, OP_ERASE, 16'h0000, 1'b0},
		'{8'h2B, OP_FETCH, 16'h0000, 1'b1}, '{8'h2B, OP_READ, 16'h0010, 1'b1},
		'{8'h1E, OP_WRITE, 16'h0400, 1'b0}, '{8'h1E, OP_ERASE, 16'h03FF, 1'b1},
		'{8'h1E, OP_FETCH, 16'h0400, 1'b1}, '{8'h15, OP_WRITE, 16'h07FF, 1'b1},
		'{8'h15, OP_WRITE, 16'h0800, 1'b0}, '{8'h2A, OP_ERASE, 16'h03FF, 1'b0},
		'{8'h2A, OP_ERASE, 16'h0400, 1'b1}};

	code_protect_top uut (
		.clk(clk), .nrst(nrst), .config_bits(config_bits),
		.prog_clock_pin(pclk), .prog_data_pin_in(pdat),
		.prog_data_pin_out(dout), .prog_data_pin_oe_n(doe_n),
		.cpu_valid(cpu_valid), .cpu_op(cpu_op), .cpu_addr(cpu_addr),
		.mem_grant(grant), .mem_refuse(refuse), .ram_addr(ram_addr),
		.ram_user_deny(deny), .pins_reserved(pins), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata)
	);
	prog_model model (.pclk(pclk), .pdat(mdat));
	assign pdat = doe_n ? mdat : dout;

	always #20 clk = ~clk;
	// Answers on the data pin are one-cycle pulses, so catch them here
	always @(posedge clk) begin
		if (doe_n === 1'b0) begin
			ans_cnt <= ans_cnt + 1;
			ans_val <= pdat;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic restart(input logic [7:0] cfg);
		@(posedge clk);
		nrst <= 1'b0;
		config_bits <= cfg;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic cpu_req(input op_type op, input logic [15:0] a, input logic g);
		@(posedge clk);
		cpu_valid <= 1'b1;
		cpu_op <= op;
		cpu_addr <= a;
		@(posedge clk);
		cpu_valid <= 1'b0;
		@(posedge clk);
		#1;
		chk(16'({grant, refuse}), 16'({g, ~g}));
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(16'(rdata), 16'(e));
	endtask
	task automatic ram_chk(input logic [15:0] a, input logic [2:0] e);
		@(posedge clk);
		ram_addr <= a;
		repeat (3) @(posedge clk);
		#1;
		chk(16'({deny, pins}), 16'(e));
	endtask
	// Three frames push a full address; only the last answer is judged
	task automatic prog_op(input op_type op, input logic [15:0] a, input logic g, input int half);
		int seen;
		model.send_frame({op, 2'b00, a[15:12]}, half);
		repeat (20) @(posedge clk);
		model.send_frame({op, a[11:6]}, half);
		repeat (20) @(posedge clk);
		seen = ans_cnt;
		model.send_frame({op, a[5:0]}, half);
		for (int i = 0; i < 40 && ans_cnt == seen; i++) @(posedge clk);
		#1;
		chk(16'(ans_cnt - seen), 16'h0001);
		chk(16'(ans_val), 16'(g));
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		restart(8'h3F);
		foreach (rows[i]) begin
			if (rows[i].cfg !== config_bits) restart(rows[i].cfg);
			cpu_req(rows[i].op, rows[i].addr, rows[i].grant);
		end
		ram_chk(16'h0000, 3'h0);
		restart(8'h30);
		prog_op(OP_READ, 16'h0FFF, 1'b0, 80);
		prog_op(OP_WRITE, 16'h1000, 1'b0, 80);
		cpu_req(OP_FETCH, 16'h0000, 1'b1);
		cpu_req(OP_READ, 16'h1000, 1'b1);
		restart(8'h39);
		prog_op(OP_READ, 16'h07FF, 1'b0, 80);
		prog_op(OP_ERASE, 16'h0800, 1'b1, 400);
		restart(8'h3C);
		prog_op(OP_WRITE, 16'h0000, 1'b1, 80);
		restart(8'h6B);
		// Later config changes must not reach the checks
		config_bits <= 8'h3F;
		ram_chk(16'h004F, 3'h7);
		ram_chk(16'h0050, 3'h3);
		reg_read(REG_CONFIG, 8'h6B);
		reg_read(REG_STATUS, 8'h05);
		reg_write(REG_CONFIG, 8'h00);
		reg_read(REG_CONFIG, 8'h6B);
		reg_write(REG_REFUSE, 8'h00);
		cpu_req(OP_WRITE, 16'h0FFF, 1'b0);
		reg_read(REG_REFUSE, 8'h01);
		reg_read(4'hF, 8'h00);
		prog_op(OP_READ, 16'h0000, 1'b0, 80);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
